//--- common/erase_host_pkg.sv
/*
 * Constants, register map and pin bundle of the block-erase host controller.
 * Assumes a 50 MHz pclk and an asynchronous parallel flash part on the far side.
 */
// Operation
// - Erase opens with a setup write of code 20H.
// - Setup write address is any location inside the target block.
// - Confirm write of D0H at a block address launches the erase.
// - Chip or output enable toggles between polls to refresh status.
// - Full error check may follow each erase or a series.
// - Clear the error bits when an error is found, before retrying; without CFG_AUTO_CLEAR, only locked or low-supply bits stop a new erase.
// - After the last write, command FFH returns the part to array read.
package erase_host_pkg;

    // ****************************************************************
    // Flash commands and status byte fields
    // ****************************************************************
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam int machine_ready_flag = 7;
    localparam int erase_fail_flag = 5;
    localparam int program_fail_flag = 4;
    localparam int supply_low_flag = 3;
    localparam int locked_block_flag = 1;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] STICKY_ERR_MASK = 8'h3a;
    localparam int FLASH_AW = 22;

    // ****************************************************************
    // Bus timing, in ns and in pclk cycles
    // ****************************************************************
    localparam int CLK_NS = 20;
    localparam int T_WP_NS = 60;
    localparam int T_ACC_NS = 70;
    localparam int T_GAP_NS = 40;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] WR_LAST = 4'(WP_CYC + 2);
    localparam logic [3:0] RD_LAST = 4'(ACC_CYC + 2);
    localparam logic [3:0] GAP_LAST = 4'(GAP_CYC - 1);
    localparam logic [3:0] WP_FIRST = 4'h1;
    localparam logic [3:0] WP_END = 4'(WP_CYC);

    // ****************************************************************
    // Register map (byte offsets) and fields
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam int CTRL_ERASE = 0;
    localparam int CTRL_CLEAR = 1;
    localparam int CTRL_ARRAY = 2;
    localparam int CFG_AUTO_ARRAY = 0;
    localparam int CFG_AUTO_CLEAR = 1;
    localparam int STAT_BUSY = 8;
    localparam int STAT_SEQ_ERR = 9;
    localparam int STAT_ANY_ERR = 10;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_REFUSED = 2;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP_WR = 3'b001,
        S_CONFIRM_WR = 3'b010,
        S_POLL_RD = 3'b011,
        S_POLL_GAP = 3'b100,
        S_CLEAR_WR = 3'b101,
        S_ARRAY_WR = 3'b110
    } seq_state_e;

    // Pins that the controller drives towards the flash part
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
        logic [FLASH_AW-1:0] addr;
        logic [7:0] dq;
    } flash_out_s;

    localparam flash_out_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, addr: '0, dq: 8'h00};

endpackage

//--- hdl/erase_host.sv
/*
 * APB-programmed host controller that runs the block-erase sequence on an
 * asynchronous parallel flash part: setup and confirm writes, status polling,
 * full status check, optional clear-status and return to array read.
 * Assumes the flash data pins are asynchronous to pclk, and an APB master on pclk.
 */
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module erase_host #(
    parameter logic [7:0] CLEAR_CMD = 8'h50
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output erase_host_pkg::flash_out_s flash_o,
    input wire logic [7:0] flash_dq_in,
    output logic irq
);
    import erase_host_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic is_write_state(input seq_state_e s);
        return (s == S_SETUP_WR) || (s == S_CONFIRM_WR) || (s == S_CLEAR_WR) || (s == S_ARRAY_WR);
    endfunction

    function automatic logic [7:0] cmd_code(input seq_state_e s);
        case (s)
            S_SETUP_WR: return CMD_ERASE_SETUP;
            S_CONFIRM_WR: return CMD_ERASE_CONFIRM;
            S_CLEAR_WR: return CLEAR_CMD;
            default: return CMD_READ_ARRAY;
        endcase
    endfunction

    seq_state_e state;
    seq_state_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    flash_out_s next_pins;
    logic [1:0] cfg;
    logic [FLASH_AW-1:0] erase_addr;
    logic [7:0] status_byte;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire wr_en = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_CFG) || (paddr == OFF_ADDR) ||
                   (paddr == OFF_STATUS) || (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK);
    wire ctrl_wr = wr_en && (paddr == OFF_CTRL);
    wire idle = (state == S_IDLE);
    // Locked or low-supply leftovers block new erases until cleared
    wire hold_off = status_byte[locked_block_flag] || status_byte[supply_low_flag];
    wire erase_req = ctrl_wr && idle && pwdata[CTRL_ERASE];
    wire erase_go = erase_req && !hold_off;
    wire refuse_ev = erase_req && hold_off;
    wire clear_go = ctrl_wr && idle && !pwdata[CTRL_ERASE] && pwdata[CTRL_CLEAR];
    wire array_go = ctrl_wr && idle && !pwdata[CTRL_ERASE] && !pwdata[CTRL_CLEAR] && pwdata[CTRL_ARRAY];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ****************************************************************
    // Status evaluation of the byte read back
    // ****************************************************************
    wire wr_last = is_write_state(state) && (cnt == WR_LAST);
    wire rd_capture = (state == S_POLL_RD) && (cnt == RD_LAST);
    wire poll_ready = dq_sync[machine_ready_flag];
    wire seq_err = dq_sync[erase_fail_flag] && dq_sync[program_fail_flag];
    wire any_err = dq_sync[locked_block_flag] || dq_sync[supply_low_flag] ||
                   dq_sync[erase_fail_flag] || dq_sync[program_fail_flag];
    wire done_ev = rd_capture && poll_ready;
    wire err_ev = done_ev && any_err;
    wire [2:0] irq_set = {refuse_ev, err_ev, done_ev};
    wire [2:0] irq_clr = (wr_en && (paddr == OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0;
    wire seq_err_held = status_byte[erase_fail_flag] && status_byte[program_fail_flag];
    wire any_err_held = status_byte[locked_block_flag] || status_byte[supply_low_flag] ||
                        status_byte[erase_fail_flag] || status_byte[program_fail_flag];

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        next_cnt = cnt + 4'h1;
        case (state)
            S_IDLE:
            begin
                next_cnt = 4'h0;
                if (erase_go)
                    next_state = S_SETUP_WR;
                else if (clear_go)
                    next_state = S_CLEAR_WR;
                else if (array_go)
                    next_state = S_ARRAY_WR;
            end
            S_SETUP_WR:
            begin
                if (wr_last)
                begin
                    next_state = S_CONFIRM_WR;
                    next_cnt = 4'h0;
                end
            end
            S_CONFIRM_WR:
            begin
                if (wr_last)
                begin
                    next_state = S_POLL_RD;
                    next_cnt = 4'h0;
                end
            end
            S_POLL_RD:
            begin
                if (rd_capture)
                begin
                    next_cnt = 4'h0;
                    if (!poll_ready)
                        next_state = S_POLL_GAP;
                    else if (any_err && cfg[CFG_AUTO_CLEAR])
                        next_state = S_CLEAR_WR;
                    else if (cfg[CFG_AUTO_ARRAY])
                        next_state = S_ARRAY_WR;
                    else
                        next_state = S_IDLE;
                end
            end
            S_POLL_GAP:
            begin
                if (cnt == GAP_LAST)
                begin
                    next_state = S_POLL_RD;
                    next_cnt = 4'h0;
                end
            end
            S_CLEAR_WR:
            begin
                if (wr_last)
                begin
                    next_state = cfg[CFG_AUTO_ARRAY] ? S_ARRAY_WR : S_IDLE;
                    next_cnt = 4'h0;
                end
            end
            S_ARRAY_WR:
            begin
                if (wr_last)
                begin
                    next_state = S_IDLE;
                    next_cnt = 4'h0;
                end
            end
            default:
            begin
                next_state = S_IDLE;
                next_cnt = 4'h0;
            end
        endcase
    end

    // ****************************************************************
    // Pin values for the coming cycle; registered so the pins never glitch
    // ****************************************************************
    wire nxt_wr = is_write_state(next_state);
    wire nxt_rd = (next_state == S_POLL_RD);
    wire nxt_wr_live = nxt_wr && (next_cnt != WR_LAST);
    wire nxt_we = nxt_wr && (next_cnt >= WP_FIRST) && (next_cnt <= WP_END);
    // Same block address serves setup and confirm
    assign next_pins = '{ce_n: !(nxt_wr_live || nxt_rd), oe_n: !nxt_rd, we_n: !nxt_we,
                         dq_oe: nxt_wr_live, addr: erase_addr, dq: cmd_code(next_state)};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;
            cnt <= 4'h0;
            flash_o <= PINS_IDLE;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            flash_o <= next_pins;
        end
    end

    // Two-flop synchroniser on the data pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
        end
        else
        begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= CFG_RESET;
            erase_addr <= '0;
            irq_mask <= IRQ_RESET;
        end
        else if (wr_en && (paddr == OFF_CFG))
            cfg <= pwdata[1:0];
        else if (wr_en && (paddr == OFF_ADDR) && idle)
            erase_addr <= pwdata[FLASH_AW-1:0];
        else if (wr_en && (paddr == OFF_IRQ_MASK))
            irq_mask <= pwdata[2:0];
    end

    // Host copy of the flash status: errors stay until a clear command goes out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_byte <= STATUS_RESET;
        else if (rd_capture)
            status_byte <= dq_sync | (status_byte & STICKY_ERR_MASK);
        else if (wr_last && (state == S_CLEAR_WR))
            status_byte <= STATUS_RESET;
    end

    // Sticky events; a new event outweighs a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= IRQ_RESET;
        else
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data captured in the setup phase, presented in the access phase
    wire [31:0] rd_mux = (paddr == OFF_CFG) ? {30'h0, cfg} :
                         (paddr == OFF_ADDR) ? {{(32-FLASH_AW){1'b0}}, erase_addr} :
                         (paddr == OFF_STATUS) ? {21'h0, any_err_held, seq_err_held, !idle, status_byte} :
                         (paddr == OFF_IRQ_STAT) ? {29'h0, irq_stat} :
                         (paddr == OFF_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_setup)
            prdata <= rd_mux;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_SETUP_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_SETUP_WR && !flash_o.we_n) |-> (flash_o.dq == CMD_ERASE_SETUP && flash_o.dq_oe && !flash_o.ce_n))
        else $error("erase setup write does not carry 20H");
    AST_CONFIRM_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_SETUP_WR && wr_last) |=> (state == S_CONFIRM_WR) ##1 (cnt == 4'h1))
        else $error("confirm does not follow setup");
    AST_CONFIRM_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_CONFIRM_WR && $fell(flash_o.we_n)) |-> (flash_o.dq == CMD_ERASE_CONFIRM &&
        flash_o.addr == $past(flash_o.addr, WP_CYC + 3)))
        else $error("confirm write code or block address wrong");
    AST_WE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flash_o.we_n) |-> (!flash_o.we_n)[*3] ##1 flash_o.we_n)
        else $error("write pulse width wrong");
    AST_BUSY_REPOLL: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_capture && !poll_ready) |=> (flash_o.ce_n && flash_o.oe_n)[*2] ##1 !flash_o.oe_n)
        else $error("busy status not followed by a fresh read strobe");
    AST_ERR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (done_ev && (dq_sync[erase_fail_flag] || dq_sync[supply_low_flag])) |=> irq_stat[IRQ_ERR] && any_err_held)
        else $error("erase error not reported");
    AST_SEQ_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (done_ev && seq_err) |=> seq_err_held)
        else $error("sequence error not reported");
    AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && idle && pwdata[CTRL_ERASE] && hold_off) |=> (state == S_IDLE && irq_stat[IRQ_REFUSED]))
        else $error("erase started over a locked or supply error");
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (any_err_held && !(state == S_CLEAR_WR)) |=> any_err_held)
        else $error("error bits dropped without a clear command");
    AST_ARRAY_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        (done_ev && !any_err && cfg[CFG_AUTO_ARRAY]) |=> ##2 (!flash_o.we_n && flash_o.dq == CMD_READ_ARRAY))
        else $error("read array command missing after erase");

    COV_ERASE_OK: cover property (@(posedge pclk) disable iff (!presetn) done_ev && !any_err);
    COV_ERASE_ERR: cover property (@(posedge pclk) disable iff (!presetn) err_ev);
    COV_REFUSED: cover property (@(posedge pclk) disable iff (!presetn) refuse_ev);
    COV_AUTO_CLEAR: cover property (@(posedge pclk) disable iff (!presetn) state == S_CLEAR_WR && wr_last);

endmodule

//--- bench/flash_part_model.sv
/*
 * Behavioural flash part facing the erase host: command decode, status byte,
 * erase outcome knobs. Assumes the bench resolves the shared data wire.
 */
`timescale 1ns/1ps
module flash_part_model #(
    parameter logic [7:0] CLEAR_CODE = 8'h50
)
(
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [21:0] addr,
    input wire logic [7:0] dq_in,
    input wire logic [7:0] busy_reads,
    input wire logic lock_en,
    input wire logic [5:0] lock_block,
    input wire logic supply_low,
    input wire logic erase_bad,
    input wire logic seq_bad,
    output logic [7:0] dq_out
);
    logic [7:0] status = 8'h80;
    logic [7:0] shown = 8'h80;
    logic status_mode = 1'b0;
    logic setup_seen = 1'b0;
    logic [5:0] setup_block = 6'h00;
    int busy_left = 0;
    wire read_n = ce_n | oe_n;

    // ********
    // Command decode on the rising write strobe; block is the upper address bits
    // ********
    always @(posedge we_n)
    begin
        if (!ce_n && setup_seen)
        begin
            setup_seen = 1'b0;
            if (dq_in != 8'hd0 || seq_bad || addr[21:16] != setup_block)
                status[5:4] = 2'b11;
            else if (status[1] || status[3])
                status = status;
            else if (lock_en && addr[21:16] == lock_block)
                status[1] = 1'b1;
            else if (supply_low)
                status[3] = 1'b1;
            else
            begin
                status[5] = status[5] | erase_bad;
                busy_left = busy_reads;
            end
        end
        else if (!ce_n && dq_in == 8'h20)
        begin
            setup_seen = 1'b1;
            setup_block = addr[21:16];
            status_mode = 1'b1;
        end
        else if (!ce_n && dq_in == CLEAR_CODE)
            status = status & 8'hc5;
        else if (!ce_n && dq_in == 8'hff)
            status_mode = 1'b0;
    end

    // Fresh value only on a new read strobe; erase time is counted in reads
    always @(negedge read_n)
    begin
        shown = status_mode ? {busy_left == 0, status[6:0]} : 8'hff;
        if (busy_left > 0)
            busy_left = busy_left - 1;
    end

    // Deselected: drive the inverse so a stale byte cannot pass for a read
    assign dq_out = read_n ? ~shown : shown;
endmodule

//--- bench/erase_host_tb.sv
/*
 * Self-checking bench for the erase host: APB master tasks, pin monitor, scenarios.
 * Assumes the flash part model and the host package are compiled first.
 */
`timescale 1ns/1ps
module erase_host_tb;
    import erase_host_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic last_err;
    flash_out_s flash_o;
    logic [7:0] part_dq;
    logic [7:0] busy_reads = 8'h00;
    logic lock_en = 1'b0;
    logic [5:0] lock_block = 6'h12;
    logic supply_low = 1'b0;
    logic erase_bad = 1'b0;
    logic seq_bad = 1'b0;
    logic prev_we_n = 1'b1;
    logic prev_rd_n = 1'b1;
    logic [29:0] cmd_q[$];
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_reads = 0;
    wire [7:0] dq_bus = flash_o.dq_oe ? flash_o.dq : part_dq;

    always #10 pclk = ~pclk;

    erase_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_o(flash_o), .flash_dq_in(dq_bus), .irq(irq));

    flash_part_model part (.ce_n(flash_o.ce_n), .oe_n(flash_o.oe_n), .we_n(flash_o.we_n),
        .addr(flash_o.addr), .dq_in(dq_bus), .busy_reads(busy_reads), .lock_en(lock_en),
        .lock_block(lock_block), .supply_low(supply_low), .erase_bad(erase_bad), .seq_bad(seq_bad),
        .dq_out(part_dq));

    // ********
    // Pin monitor and hang guard
    // ********
    always @(posedge pclk)
    begin
        prev_we_n <= flash_o.we_n;
        prev_rd_n <= flash_o.ce_n | flash_o.oe_n;
        if (!prev_we_n && flash_o.we_n && !flash_o.ce_n)
            cmd_q.push_back({flash_o.addr, flash_o.dq});
        if (prev_rd_n && !(flash_o.ce_n | flash_o.oe_n))
            n_reads++;
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            summarize;
        end
    end

    task automatic summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held from setup until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Bounded poll of the busy flag
    task automatic run(input logic [31:0] ctrl);
        logic [31:0] q;
        q = 32'h100;
        wr(OFF_CTRL, ctrl);
        for (int i = 0; i < 300 && q[STAT_BUSY] !== 1'b0; i++)
            apb(1'b0, OFF_STATUS, 32'h0, q);
        chk({31'h0, q[STAT_BUSY]}, 32'h0);
    endtask

    // Commands seen on the pins, oldest first in the top byte of codes
    task automatic check_cmds(input int n, input logic [31:0] codes, input logic [21:0] a);
        chk(32'(cmd_q.size()), 32'(n));
        foreach (cmd_q[i])
            if (i < 4)
                chk({2'b00, cmd_q[i]}, {2'b00, a, codes[31 - 8 * i -: 8]});
        cmd_q.delete();
    endtask

    // ********
    // Scenarios
    // ********
    task automatic s_reset;
        rd_chk(OFF_CFG, 32'h0);
        rd_chk(OFF_ADDR, 32'h0);
        rd_chk(OFF_IRQ_MASK, 32'h0);
        rd_chk(OFF_IRQ_STAT, 32'h0);
        rd_chk(OFF_STATUS, 32'h80);
        rd_chk(8'h20, 32'h0);
        chk({31'h0, last_err}, 32'h1);
    endtask

    // Slow part: three busy polls before ready, auto return to array read
    task automatic s_plain;
        busy_reads <= 8'h03;
        wr(OFF_ADDR, 32'h123456);
        wr(OFF_CFG, 32'h1);
        wr(OFF_IRQ_MASK, 32'h7);
        rd_chk(OFF_ADDR, 32'h123456);
        n_reads = 0;
        run(32'h1);
        check_cmds(3, 32'h20d0ff00, 22'h123456);
        chk(32'(n_reads), 32'h4);
        rd_chk(OFF_STATUS, 32'h80);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        busy_reads <= 8'h00;
    endtask

    // One error kind, a second erase, then the clear command
    task automatic s_error(input logic [3:0] knobs, input logic [7:0] exp, input logic refuse);
        logic [31:0] st;
        st = {21'h0, |exp[5:1], exp[5] & exp[4], 1'b0, exp};
        wr(OFF_CFG, 32'h0);
        wr(OFF_IRQ_STAT, 32'h7);
        {lock_en, supply_low, erase_bad, seq_bad} <= knobs;
        run(32'h1);
        cmd_q.delete();
        rd_chk(OFF_STATUS, st);
        rd_chk(OFF_IRQ_STAT, 32'h3);
        {lock_en, supply_low, erase_bad, seq_bad} <= 4'h0;
        wr(OFF_IRQ_STAT, 32'h7);
        run(32'h1);
        check_cmds(refuse ? 0 : 2, 32'h20d00000, 22'h123456);
        rd_chk(OFF_STATUS, st);
        if (refuse)
            rd_chk(OFF_IRQ_STAT, 32'h4);
        run(32'h2);
        check_cmds(1, 32'h50000000, 22'h123456);
        rd_chk(OFF_STATUS, 32'h80);
    endtask

    // Auto clear and auto array read; masked events keep the line low
    task automatic s_auto;
        wr(OFF_CFG, 32'h3);
        wr(OFF_IRQ_MASK, 32'h0);
        erase_bad <= 1'b1;
        run(32'h1);
        erase_bad <= 1'b0;
        check_cmds(4, 32'h20d050ff, 22'h123456);
        rd_chk(OFF_STATUS, 32'h80);
        rd_chk(OFF_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_CFG, 32'h0);
        run(32'h6);
        check_cmds(1, 32'h50000000, 22'h123456);
        run(32'h4);
        check_cmds(1, 32'hff000000, 22'h123456);
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        s_reset;
        s_plain;
        s_error(4'b1000, 8'h82, 1'b1);
        s_error(4'b0100, 8'h88, 1'b1);
        s_error(4'b0010, 8'ha0, 1'b0);
        s_error(4'b0001, 8'hb0, 1'b0);
        s_auto;
        summarize;
    end
endmodule
